/* File: logic/pin_sync.sv */
// Two-flop synchroniser for pin inputs, frozen by the clock enable
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic clk_en, // Clock enable
    input wire logic [WIDTH-1:0] async_in, // Pin level from outside the clock domain
    output logic [WIDTH-1:0] sync_out // Synchronised level
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= INIT;
            sync_out <= INIT;
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

/* File: logic/power_pin_pkg.sv */
// Shared constants for the power, reset and fault pin controller
package power_pin_pkg;
    localparam int CORE_COUNT = 2;
    localparam int BOOT_SEL_W = 3;
    localparam int CLK_PERIOD_NS = 100;
    // Time the reset state is held after the hardware reset pin is released
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYC =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 8;
    localparam logic [BOOT_SEL_W-1:0] BOOT_SEL_RESET = 3'h0;
    localparam logic FAULT_ACTIVE = 1'h1;

    typedef enum logic [2:0] {
        PWR_RESET,
        PWR_ACTIVE,
        PWR_DEEP_SLEEP,
        PWR_HIBERNATE,
        PWR_WAKE_WAIT
    } power_state_e;
endpackage

/* File: logic/power_state_pin_control.sv */
// Power state sequencing and system power, reset and fault pin control
// Operation
// - Wake output low only in hibernate
// - Per-core idle flag low when idle/reset
// - Deep-sleep flag low in deep sleep
// - Reset output high during reset state
// - Hardware reset input resets the device
// - Boot after hibernate only with supply good
// - Fault pin reports or senses per mode
// - Second fault pin carries the complement
// - Boot mode chosen from boot select pins
`timescale 1ns/1ps
module power_state_pin_control #(
    parameter int CORES = power_pin_pkg::CORE_COUNT,
    parameter int BOOT_W = power_pin_pkg::BOOT_SEL_W
) (
    input wire logic core_clk, // System clock, 10 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic clk_en, // Clock enable, freezes all state when low
    input wire logic hardware_reset_in, // Hardware reset pin, active high
    input wire logic supply_good_in, // Core supply good pin
    input wire logic [BOOT_W-1:0] boot_select_in, // Boot mode select pins
    input wire logic fault_sense_mode, // 1: fault pins sense, 0: fault pins report
    input wire logic fault_pin_in, // Fault pin level
    output logic fault_pin_out, // Fault pin drive value
    output logic fault_pin_oe, // Fault pin output enable
    input wire logic fault_comp_pin_in, // Complement fault pin level
    output logic fault_comp_pin_out, // Complement fault pin drive value
    output logic fault_comp_pin_oe, // Complement fault pin output enable
    input wire logic internal_fault, // Internal fault, level
    input wire logic [CORES-1:0] core_idle_req, // Core is idle, per core
    input wire logic [CORES-1:0] core_hold_req, // Core is held in reset, per core
    input wire logic deep_sleep_req, // Enter deep sleep, pulse
    input wire logic hibernate_req, // Enter hibernate, pulse
    input wire logic wake_event, // Leave deep sleep or hibernate, pulse
    output logic regulator_wake_out, // Regulator enable
    output logic [CORES-1:0] core_idle_flag_n, // Core idle indicator, active low
    output logic deep_sleep_flag_n, // Deep sleep indicator, active low
    output logic reset_state_out, // Reset state indicator
    output logic [BOOT_W-1:0] boot_mode_out, // Boot mode in force
    output logic boot_start, // Boot begins, one-cycle pulse
    output logic external_fault_out, // Fault sensed on the pins
    output logic [2:0] power_state_out // Current power state code
);
    logic hw_reset_s;
    logic supply_good_s;
    logic [BOOT_W-1:0] boot_sel_s;
    logic fault_in_s;
    logic comp_in_s;

    power_pin_pkg::power_state_e state_r;
    power_pin_pkg::power_state_e state_nxt;
    logic [power_pin_pkg::HOLD_CNT_W-1:0] hold_cnt_r;
    logic [power_pin_pkg::HOLD_CNT_W-1:0] hold_cnt_nxt;
    logic hw_reset_d_r;
    logic [BOOT_W-1:0] boot_mode_r;

    pin_sync #(
        .WIDTH(1),
        .INIT(1'h1)
    ) u_sync_hwrst (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(hardware_reset_in),
        .sync_out(hw_reset_s)
    );

    pin_sync #(
        .WIDTH(1),
        .INIT(1'h0)
    ) u_sync_pwrgd (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(supply_good_in),
        .sync_out(supply_good_s)
    );

    pin_sync #(
        .WIDTH(BOOT_W),
        .INIT('0)
    ) u_sync_boot (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(boot_select_in),
        .sync_out(boot_sel_s)
    );

    pin_sync #(
        .WIDTH(2),
        .INIT(2'h2)
    ) u_sync_fault (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({fault_comp_pin_in, fault_pin_in}),
        .sync_out({comp_in_s, fault_in_s})
    );

    // Reset release seen on the synchronised pin
    wire hw_release = hw_reset_d_r & ~hw_reset_s;
    wire hold_done = (hold_cnt_r == '0);
    wire leaving_reset = (state_r == power_pin_pkg::PWR_RESET) & ~hw_reset_s & hold_done;

    always_comb begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        if (hw_reset_s) begin
            state_nxt = power_pin_pkg::PWR_RESET;
            hold_cnt_nxt = power_pin_pkg::HOLD_CNT_W'(power_pin_pkg::RESET_HOLD_CYC);
        end else begin
            unique case (state_r)
                power_pin_pkg::PWR_RESET: begin
                    if (hold_done) begin
                        state_nxt = power_pin_pkg::PWR_ACTIVE;
                    end else begin
                        hold_cnt_nxt = hold_cnt_r - 1'b1;
                    end
                end
                power_pin_pkg::PWR_ACTIVE: begin
                    if (hibernate_req) begin
                        state_nxt = power_pin_pkg::PWR_HIBERNATE;
                    end else if (deep_sleep_req) begin
                        state_nxt = power_pin_pkg::PWR_DEEP_SLEEP;
                    end
                end
                power_pin_pkg::PWR_DEEP_SLEEP: begin
                    if (wake_event) begin
                        state_nxt = power_pin_pkg::PWR_ACTIVE;
                    end
                end
                power_pin_pkg::PWR_HIBERNATE: begin
                    if (wake_event) begin
                        state_nxt = power_pin_pkg::PWR_WAKE_WAIT;
                    end
                end
                power_pin_pkg::PWR_WAKE_WAIT: begin
                    if (supply_good_s) begin
                        state_nxt = power_pin_pkg::PWR_RESET;
                        hold_cnt_nxt = power_pin_pkg::HOLD_CNT_W'(power_pin_pkg::RESET_HOLD_CYC);
                    end
                end
                default: begin
                    state_nxt = power_pin_pkg::PWR_RESET;
                end
            endcase
        end
    end

    // Output levels decoded from the next state so pins follow state at once
    wire in_reset_nxt = (state_nxt == power_pin_pkg::PWR_RESET);
    wire wake_nxt = (state_nxt != power_pin_pkg::PWR_HIBERNATE);
    wire sleep_n_nxt = (state_nxt != power_pin_pkg::PWR_DEEP_SLEEP);
    wire boot_go = leaving_reset;
    wire [BOOT_W-1:0] boot_mode_nxt = hw_release ? boot_sel_s : boot_mode_r;

    // Idle flag low while core idles, is held, or the device is in reset
    logic [CORES-1:0] idle_n_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < CORES; gi++) begin : g_core
            assign idle_n_nxt[gi] = ~(core_idle_req[gi] | core_hold_req[gi] | in_reset_nxt);
        end
    endgenerate

    wire fault_report = (internal_fault == power_pin_pkg::FAULT_ACTIVE);
    wire fault_sensed = fault_sense_mode & (fault_in_s | ~comp_in_s);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= power_pin_pkg::PWR_RESET;
            hold_cnt_r <= power_pin_pkg::HOLD_CNT_W'(power_pin_pkg::RESET_HOLD_CYC);
            hw_reset_d_r <= 1'h1;
        end else if (clk_en) begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            hw_reset_d_r <= hw_reset_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            boot_mode_r <= power_pin_pkg::BOOT_SEL_RESET;
            boot_start <= 1'h0;
        end else if (clk_en) begin
            boot_mode_r <= boot_mode_nxt;
            boot_start <= boot_go;
        end
    end

    assign boot_mode_out = boot_mode_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regulator_wake_out <= 1'h1;
            deep_sleep_flag_n <= 1'h1;
            reset_state_out <= 1'h1;
            core_idle_flag_n <= '0;
            power_state_out <= 3'h0;
        end else if (clk_en) begin
            regulator_wake_out <= wake_nxt;
            deep_sleep_flag_n <= sleep_n_nxt;
            reset_state_out <= in_reset_nxt;
            core_idle_flag_n <= idle_n_nxt;
            power_state_out <= 3'(state_nxt);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fault_pin_out <= 1'h0;
            fault_comp_pin_out <= 1'h1;
            fault_pin_oe <= 1'h0;
            fault_comp_pin_oe <= 1'h0;
            external_fault_out <= 1'h0;
        end else if (clk_en) begin
            fault_pin_out <= fault_report;
            fault_comp_pin_out <= ~fault_report;
            fault_pin_oe <= ~fault_sense_mode;
            fault_comp_pin_oe <= ~fault_sense_mode;
            external_fault_out <= fault_sensed;
        end
    end
endmodule

/* File: verification/power_state_pin_control_chk.sv */
// Port assertions for the power state pin controller
`timescale 1ns/1ps
module power_state_pin_control_chk #(
    parameter int CORES = 2,
    parameter int BOOT_W = 3
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Enable
    input wire logic hardware_reset_in, // Pin
    input wire logic supply_good_in, // Pin
    input wire logic fault_sense_mode, // Mode
    input wire logic internal_fault, // Fault
    input wire logic fault_pin_out, // Pin
    input wire logic fault_pin_oe, // Pin
    input wire logic fault_comp_pin_out, // Pin
    input wire logic fault_comp_pin_oe, // Pin
    input wire logic [CORES-1:0] core_idle_req, // Idle
    input wire logic [CORES-1:0] core_hold_req, // Hold
    input wire logic regulator_wake_out, // Pin
    input wire logic [CORES-1:0] core_idle_flag_n, // Pin
    input wire logic deep_sleep_flag_n, // Pin
    input wire logic reset_state_out, // Pin
    input wire logic [BOOT_W-1:0] boot_mode_out, // Mode
    input wire logic boot_start, // Pulse
    input wire logic [2:0] power_state_out // State
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence hw_held;
        (hardware_reset_in && clk_en) [*3];
    endsequence
    sequence leave_wait;
        power_state_out == 3'h4 ##1 power_state_out == 3'h0;
    endsequence
    chk_wake_hib: assert property (regulator_wake_out == (power_state_out != 3'h3))
        else $error("wake output wrong for power state");
    chk_idle_flags: assert property ($past(clk_en) && !$past(rst) |-> core_idle_flag_n ==
        ~($past(core_idle_req) | $past(core_hold_req) | {CORES{reset_state_out}}))
        else $error("idle flags wrong");
    chk_sleep_flag: assert property (deep_sleep_flag_n == (power_state_out != 3'h2))
        else $error("deep sleep flag wrong");
    chk_reset_out: assert property (reset_state_out == (power_state_out == 3'h0))
        else $error("reset output wrong");
    chk_hw_reset: assert property (hw_held |=> reset_state_out)
        else $error("hardware reset not honoured");
    chk_boot_supply: assert property (leave_wait |-> $past(supply_good_in, 3))
        else $error("boot left wait without supply good");
    chk_boot_pulse: assert property (boot_start |-> $past(reset_state_out) && !reset_state_out)
        else $error("boot pulse outside reset exit");
    chk_fault_report: assert property ($past(clk_en) && !$past(rst) |->
        fault_pin_out == $past(internal_fault) && fault_pin_oe == !$past(fault_sense_mode))
        else $error("fault pin drive wrong");
    chk_fault_comp: assert property (fault_comp_pin_out == !fault_pin_out &&
        fault_comp_pin_oe == fault_pin_oe)
        else $error("complement fault pin wrong");
    chk_boot_hold: assert property ($past(clk_en) && !reset_state_out |-> $stable(boot_mode_out))
        else $error("boot mode changed outside reset");
endmodule
bind power_state_pin_control power_state_pin_control_chk #(.CORES(CORES), .BOOT_W(BOOT_W))
    power_state_pin_control_chk_inst (.core_clk, .rst, .clk_en, .hardware_reset_in,
    .supply_good_in, .fault_sense_mode, .internal_fault, .fault_pin_out, .fault_pin_oe,
    .fault_comp_pin_out, .fault_comp_pin_oe, .core_idle_req, .core_hold_req,
    .regulator_wake_out, .core_idle_flag_n, .deep_sleep_flag_n, .reset_state_out,
    .boot_mode_out, .boot_start, .power_state_out);

/* File: verification/power_state_pin_control_test.sv */
// Self-checking bench for the power state pin controller
`timescale 1ns/1ps
module power_state_pin_control_test;
    logic core_clk = 0, rst = 1, hardware_reset_in = 1, fault_sense_mode = 0;
    logic internal_fault = 0, deep_sleep_req = 0, hibernate_req = 0, wake_event = 0;
    logic ext_fault = 0, supply_good_in, fault_pin_out, fault_pin_oe, fault_comp_pin_out;
    logic fault_comp_pin_oe, regulator_wake_out, deep_sleep_flag_n, reset_state_out;
    logic boot_start, external_fault_out;
    logic clk_en = 1, ext_comp = 1;
    logic [2:0] boot_select_in = 3'h5, boot_mode_out, power_state_out;
    logic [1:0] core_idle_req = 2'h0, core_hold_req = 2'h0, core_idle_flag_n;
    int n_fail = 0, comparisons = 0;
    // Rows: idle request, hold request, expected active-low flags
    logic [5:0] idle_rows [4] = '{6'h03, 6'h12, 6'h09, 6'h24};
    // Pin levels resolved from the device enables and the board's own drive
    wire logic fault_w = fault_pin_oe ? fault_pin_out : ext_fault;
    wire logic comp_w = fault_comp_pin_oe ? fault_comp_pin_out : ext_comp;
    power_state_pin_control power_state_pin_control_inst (.core_clk, .rst, .clk_en,
        .hardware_reset_in, .supply_good_in, .boot_select_in, .fault_sense_mode,
        .fault_pin_in(fault_w), .fault_pin_out, .fault_pin_oe, .fault_comp_pin_in(comp_w),
        .fault_comp_pin_out, .fault_comp_pin_oe, .internal_fault, .core_idle_req,
        .core_hold_req, .deep_sleep_req, .hibernate_req, .wake_event, .regulator_wake_out,
        .core_idle_flag_n, .deep_sleep_flag_n, .reset_state_out, .boot_mode_out, .boot_start,
        .external_fault_out, .power_state_out);
    regulator_model regulator_model_inst (.core_clk, .regulator_wake_out, .supply_good_in);
    always #50 core_clk = ~core_clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_boot;
        for (int i = 0; i < 40 && boot_start !== 1'b1; i++) cyc(1);
        check(boot_start, 8'h1);
    endtask
    task summarize;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        summarize;
    end
    initial begin
        cyc(5);
        rst = 0;
        check(reset_state_out, 8'h1);
        check(regulator_wake_out, 8'h1);
        cyc(4);
        check(core_idle_flag_n, 8'h0);
        check(reset_state_out, 8'h1);
        hardware_reset_in = 0;
        wait_boot;
        check(boot_mode_out, 8'h5);
        boot_select_in = 3'h2;
        foreach (idle_rows[k]) begin
            {core_idle_req, core_hold_req} = idle_rows[k][5:2];
            cyc(1);
            check(core_idle_flag_n, idle_rows[k][1:0]);
        end
        {core_idle_req, core_hold_req} = 4'h0;
        // Frozen core ignores requests and keeps every output level
        {clk_en, hibernate_req} = 2'h1;
        cyc(2);
        check({regulator_wake_out, power_state_out}, 8'h9);
        check(core_idle_flag_n, 8'h0);
        {clk_en, hibernate_req} = 2'h2;
        deep_sleep_req = 1;
        cyc(1);
        deep_sleep_req = 0;
        hibernate_req = 1;
        check(deep_sleep_flag_n, 8'h0);
        cyc(1);
        hibernate_req = 0;
        check(regulator_wake_out, 8'h1);
        wake_event = 1;
        cyc(1);
        {wake_event, hibernate_req, deep_sleep_req} = 3'h3;
        check(deep_sleep_flag_n, 8'h1);
        cyc(1);
        {hibernate_req, deep_sleep_req} = 2'h0;
        check(regulator_wake_out, 8'h0);
        check(deep_sleep_flag_n, 8'h1);
        cyc(4);
        wake_event = 1;
        cyc(1);
        wake_event = 0;
        check(regulator_wake_out, 8'h1);
        cyc(3);
        check(power_state_out, 8'h4);
        wait_boot;
        check(boot_mode_out, 8'h5);
        internal_fault = 1;
        cyc(1);
        check({fault_pin_oe, fault_pin_out, fault_comp_pin_out}, 8'h6);
        {internal_fault, fault_sense_mode, ext_fault} = 3'h3;
        cyc(4);
        check({fault_pin_oe, external_fault_out}, 8'h1);
        {ext_fault, ext_comp} = 2'h0;
        cyc(4);
        check({fault_pin_oe, external_fault_out}, 8'h1);
        ext_comp = 1;
        cyc(4);
        check({fault_pin_oe, external_fault_out}, 8'h0);
        {fault_sense_mode, ext_fault} = 2'h0;
        boot_select_in = 3'h6;
        hardware_reset_in = 1;
        cyc(4);
        check({reset_state_out, core_idle_flag_n}, 8'h4);
        hardware_reset_in = 0;
        wait_boot;
        check(boot_mode_out, 8'h6);
        summarize;
    end
endmodule

/* File: verification/regulator_model.sv */
// Core supply regulator model: supply good follows the enable after a ramp
`timescale 1ns/1ps
module regulator_model #(
    parameter int RAMP = 6
) (
    input wire logic core_clk, // System clock
    input wire logic regulator_wake_out, // Regulator enable
    output logic supply_good_in // Supply in limits
);
    int cnt = 0;
    initial supply_good_in = 1'b0;
    always @(negedge core_clk) begin
        if (regulator_wake_out !== 1'b1) begin
            cnt <= 0;
        end else if (cnt < RAMP) begin
            cnt <= cnt + 1;
        end
        // Good only once the ramp has finished, dropped at once when disabled
        supply_good_in <= (regulator_wake_out === 1'b1) && (cnt >= RAMP);
    end
endmodule
